// ### dv/core_special_registers_checker.sv
// concurrent checks on the core special-function register ports
`timescale 1ns/100ps
module core_special_registers_checker
   import core_sfr_pkg::*;
(
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic [7:0] mem_addr_i,
   input wire logic mem_rd_i,
   input wire logic mem_wr_i,
   input wire logic [7:0] mem_wdata_i,
   input wire logic [7:0] mem_rdata_o,
   input wire logic [14:0] pc_i,
   input wire logic jump_o,
   input wire logic [14:0] jump_addr_o,
   input wire logic dummy_cycle_o,
   input wire logic [1:0] prog_bank_o,
   input wire logic tbl_rd_i,
   input wire logic tbl_last_i,
   input wire logic tbl_req_o,
   input wire logic [14:0] tbl_addr_o,
   input wire logic tbl_ack_i,
   input wire logic irq_entry_i,
   input wire logic irq_return_i,
   input wire logic irq_pending_o,
   input wire logic fs_tick_i,
   input wire logic tick_irq_o,
   input wire logic slow_osc_fast_start_o
);
   // ------
   // helper state
   // ------
   logic [7:0] wd_q;
   logic [6:0] pch_q;
   logic ack_q;
   logic wr_ok;
   // writes in the cycle after a table ack are dropped, so they prove nothing
   assign wr_ok = mem_wr_i && !ack_q;
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         wd_q <= 8'h00;
         pch_q <= 7'h00;
         ack_q <= 1'b0;
      end else begin
         wd_q <= mem_wdata_i;
         pch_q <= pc_i[14:8];
         ack_q <= tbl_ack_i;
      end
   end
   // ------
   // assertions
   // ------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   AST_JUMP_TARGET: assert property (
      wr_ok && mem_addr_i == ADDR_PCL |=> jump_o && jump_addr_o == {pch_q, wd_q})
      else $error("jump target wrong");
   AST_DUMMY_WITH_JUMP: assert property (dummy_cycle_o == jump_o)
      else $error("dummy cycle not paired with jump");
   AST_PROG_BANK: assert property (
      wr_ok && mem_addr_i == ADDR_BANK |=> prog_bank_o == wd_q[6:5])
      else $error("program bank not from bits 6:5");
   AST_FAST_START: assert property (
      wr_ok && mem_addr_i == ADDR_TICK |=> slow_osc_fast_start_o == wd_q[4])
      else $error("fast start bit not from bit 4");
   AST_TBL_REQ: assert property (tbl_req_o |-> $past(tbl_rd_i) ##1 !tbl_req_o)
      else $error("table request without start");
   AST_TBL_LAST: assert property (
      tbl_rd_i && tbl_last_i ##1 tbl_req_o |-> tbl_addr_o[14:8] == TBL_LAST_PAGE)
      else $error("last page not used");
   AST_TICK_PULSE: assert property (tick_irq_o |-> $past(fs_tick_i) ##1 !tick_irq_o)
      else $error("tick pulse malformed");
   AST_IRQ_ENTRY: assert property (
      irq_entry_i && !irq_return_i && !mem_wr_i ##1 !irq_return_i && !mem_wr_i
      |=> !irq_pending_o)
      else $error("pending after interrupt entry");
   AST_FLAG_TOP: assert property (
      mem_rd_i && mem_addr_i == ADDR_FLAG |=> mem_rdata_o[7:6] == 2'h0)
      else $error("flag bits 7:6 not zero");
   cover property (jump_o);
   cover property (tbl_req_o);
   cover property (tick_irq_o);
endmodule : core_special_registers_checker

bind core_special_registers core_special_registers_checker i_chk (.*);

// ### dv/core_special_registers_tb_top.sv
// self-checking bench for the core special-function registers
`timescale 1ns/100ps
`define CHK(g, e) begin \
   n_tests++; \
   if ((g) !== (e)) begin \
      error_cnt++; \
      $display("MISMATCH t=%0t got %0h exp %0h", $time, (g), (e)); \
   end \
end
module core_special_registers_tb_top
   import core_sfr_pkg::*;
();
   logic clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic mem_rd_i = 1'b0, mem_wr_i = 1'b0, tbl_rd_i = 1'b0, tbl_last_i = 1'b0;
   logic tbl_ack_i = 1'b0, halt_i = 1'b0, kick_i = 1'b0, wdt_expired_i = 1'b0;
   logic irq_entry_i = 1'b0, irq_return_i = 1'b0, fs_tick_i = 1'b0;
   logic [7:0] mem_addr_i = 8'h00, mem_wdata_i = 8'h00, alu_operand_i = 8'h00;
   logic [7:0] tbl_dest_i = 8'h00;
   logic [14:0] pc_i = 15'h0000;
   logic [15:0] tbl_word_i = 16'h0000;
   logic [6:0] irq_req_i = 7'h00;
   alu_op_t alu_op_i = ALU_NONE;
   logic [7:0] mem_rdata_o;
   logic jump_o, dummy_cycle_o, tbl_req_o, irq_pending_o, tick_irq_o, slow_osc_fast_start_o;
   logic [14:0] jump_addr_o, tbl_addr_o;
   logic [1:0] prog_bank_o;
   int error_cnt = 0, n_tests = 0;
   logic [15:0] exp_q[$];
   logic rd_pend = 1'b0;

   core_special_registers i_dut (.*);

   always #5 clk_i = ~clk_i;

   // ------
   // drivers and scoreboard
   // ------
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : test_done

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      mem_addr_i <= a;
      mem_wdata_i <= d;
      mem_wr_i <= 1'b1;
      @(posedge clk_i);
      mem_wr_i <= 1'b0;
      @(posedge clk_i);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back({8'h00, e});
      mem_addr_i <= a;
      mem_rd_i <= 1'b1;
      @(posedge clk_i);
      mem_rd_i <= 1'b0;
      @(posedge clk_i);
   endtask : rd

   task automatic alu(input alu_op_t op, input logic [7:0] b);
      alu_op_i <= op;
      alu_operand_i <= b;
      @(posedge clk_i);
      alu_op_i <= ALU_NONE;
      @(posedge clk_i);
   endtask : alu

   // order: halt, kick, expiry, irq entry, irq return
   task automatic ctl(input logic [4:0] m);
      {halt_i, kick_i, wdt_expired_i, irq_entry_i, irq_return_i} <= m;
      @(posedge clk_i);
      {halt_i, kick_i, wdt_expired_i, irq_entry_i, irq_return_i} <= 5'h00;
      @(posedge clk_i);
   endtask : ctl

   task automatic wait_tick(output int c);
      @(posedge clk_i);
      for (c = 1; c < 9000 && tick_irq_o !== 1'b1; c++) @(posedge clk_i);
      if (c >= 9000) begin
         error_cnt++;
         $display("MISMATCH t=%0t no tick", $time);
         test_done();
      end
   endtask : wait_tick

   task automatic cmp(input logic [15:0] g);
      logic [15:0] e;
      if (exp_q.size() == 0) begin
         error_cnt++;
         $display("MISMATCH t=%0t unexpected result", $time);
      end else begin
         e = exp_q.pop_front();
         `CHK(g, e)
      end
   endtask : cmp

   // sampled mid-cycle, away from the edges that move outputs
   always @(negedge clk_i) begin
      if (rd_pend) cmp({8'h00, mem_rdata_o});
      if (jump_o) cmp({1'b0, jump_addr_o});
      if (jump_o) `CHK(dummy_cycle_o, 1'b1)
      if (tbl_req_o) cmp({1'b0, tbl_addr_o});
      rd_pend = mem_rd_i;
   end

   // ------
   // scenarios
   // ------
   initial begin
      logic [7:0] a, b, v, f;
      logic [8:0] t;
      logic [15:0] w;
      logic [14:0] p;
      logic c, h, o;
      int n, k;
      void'($urandom(54));
      repeat (2) @(posedge clk_i);
      reset_n_i <= 1'b1;
      @(posedge clk_i);
      rd(ADDR_BANK, 8'h00);
      rd(ADDR_TICK, 8'h00);
      rd(ADDR_FLAG, 8'h00);
      wr(ADDR_BANK, 8'hFF);
      rd(ADDR_BANK, 8'h63);
      `CHK(prog_bank_o, 2'h3)
      for (k = 0; k < 4; k++) begin
         wr(ADDR_BANK, k[7:0]);
         wr(8'h50, 8'hA0 + k[7:0]);
         wr(ADDR_TBLP, 8'h30 + k[7:0]);
      end
      for (k = 0; k < 4; k++) begin
         wr(ADDR_BANK, k[7:0]);
         rd(8'h50, 8'hA0 + k[7:0]);
         rd(ADDR_TBLP, 8'h33);
      end
      wr(ADDR_PTR0, 8'h50);
      rd(ADDR_PTR0, 8'h50);
      rd(ADDR_WIN0, 8'hA0);
      wr(ADDR_PTR1, 8'h50);
      rd(ADDR_WIN1, 8'hA3);
      wr(ADDR_WIN1, 8'h5C);
      rd(8'h50, 8'h5C);
      // window aimed at a window: read zero, write lost
      wr(ADDR_PTR0, ADDR_WIN1);
      wr(ADDR_WIN0, 8'h77);
      rd(ADDR_WIN0, 8'h00);
      rd(ADDR_WIN1, 8'h5C);
      for (n = 0; n < 16; n++) begin
         a = 8'($urandom);
         b = (n == 0) ? 8'h00 - a : (n == 1) ? a : 8'($urandom);
         alu(ALU_LOAD, a);
         alu(n[0] ? ALU_SUB : ALU_ADD, b);
         t = n[0] ? {1'b0, a} - {1'b0, b} : {1'b0, a} + {1'b0, b};
         c = n[0] ? (a >= b) : t[8];
         h = n[0] ? (a[3:0] >= b[3:0]) : ((5'(a[3:0]) + 5'(b[3:0])) > 5'h0F);
         o = n[0] ? (a[7] != b[7]) && (t[7] != a[7]) : (a[7] == b[7]) && (t[7] != a[7]);
         f = {4'h0, o, t[7:0] == 8'h00, h, c};
         rd(ADDR_WREG, t[7:0]);
         rd(ADDR_FLAG, f);
      end
      alu(ALU_LOAD, 8'h81);
      alu(ALU_RLC, 8'h00);
      rd(ADDR_WREG, {7'h01, f[0]});
      rd(ADDR_FLAG, {f[7:1], 1'b1});
      // the rotate left the carry set; the next two flag reads see it
      f[0] = 1'b1;
      wr(ADDR_BANK, 8'h61);
      ctl(5'h10);
      rd(ADDR_FLAG, {4'h1, f[3:0]});
      ctl(5'h04);
      rd(ADDR_FLAG, {4'h3, f[3:0]});
      rd(ADDR_BANK, 8'h61);
      wr(ADDR_FLAG, 8'hC0);
      rd(ADDR_FLAG, 8'h30);
      ctl(5'h08);
      rd(ADDR_FLAG, 8'h00);
      ctl(5'h04);
      rd(ADDR_BANK, 8'h00);
      rd(ADDR_FLAG, 8'h20);
      ctl(5'h10);
      rd(ADDR_FLAG, 8'h10);
      for (n = 0; n < 3; n++) begin
         p = 15'($urandom);
         v = 8'($urandom);
         pc_i <= p;
         rd(ADDR_PCL, p[7:0]);
         exp_q.push_back({1'b0, p[14:8], v});
         wr(ADDR_PCL, v);
      end
      for (k = 0; k < 2; k++) begin
         a = 8'($urandom);
         b = 8'($urandom);
         w = 16'($urandom);
         wr(ADDR_TBLP, a);
         wr(ADDR_TBHP, b);
         exp_q.push_back({1'b0, (k == 1) ? 7'h7F : b[6:0], a});
         tbl_last_i <= k[0];
         tbl_dest_i <= 8'h60;
         tbl_rd_i <= 1'b1;
         @(posedge clk_i);
         tbl_rd_i <= 1'b0;
         @(posedge clk_i);
         tbl_word_i <= w;
         tbl_ack_i <= 1'b1;
         @(posedge clk_i);
         tbl_ack_i <= 1'b0;
         repeat (2) @(posedge clk_i);
         rd(ADDR_TABLE_RESULT_HIGH, w[15:8]);
         rd(8'h60, w[7:0]);
         wr(ADDR_TABLE_RESULT_HIGH, ~w[15:8]);
         rd(ADDR_TABLE_RESULT_HIGH, w[15:8]);
      end
      irq_req_i <= 7'h01;
      wr(ADDR_IRQA, 8'h03);
      @(posedge clk_i);
      `CHK(irq_pending_o, 1'b1)
      ctl(5'h02);
      @(posedge clk_i);
      `CHK(irq_pending_o, 1'b0)
      rd(ADDR_IRQA, 8'h02);
      ctl(5'h01);
      @(posedge clk_i);
      `CHK(irq_pending_o, 1'b1)
      irq_req_i <= 7'h02;
      repeat (2) @(posedge clk_i);
      `CHK(irq_pending_o, 1'b0)
      irq_req_i <= 7'h40;
      wr(ADDR_IRQB, 8'h08);
      @(posedge clk_i);
      `CHK(irq_pending_o, 1'b1)
      // fs every cycle, so one period in cycles equals the divide ratio
      fs_tick_i <= 1'b1;
      for (k = 0; k < 6; k += 2) begin
         wr(ADDR_TICK, 8'hF8 | k[7:0]);
         rd(ADDR_TICK, 8'h10 | k[7:0]);
         wait_tick(n);
         wait_tick(n);
         `CHK(n, 256 << k)
      end
      repeat (2) @(posedge clk_i);
      `CHK(exp_q.size(), 0)
      test_done();
   end
endmodule : core_special_registers_tb_top

// ### verilog/core_sfr_pkg.sv
// constants shared by the core special-function register set
package core_sfr_pkg;

   // ----------------------------------------
   // special-function register addresses
   // ----------------------------------------
   localparam logic [7:0] ADDR_WIN0 = 8'h00;
   localparam logic [7:0] ADDR_PTR0 = 8'h01;
   localparam logic [7:0] ADDR_WIN1 = 8'h02;
   localparam logic [7:0] ADDR_PTR1 = 8'h03;
   localparam logic [7:0] ADDR_BANK = 8'h04;
   localparam logic [7:0] ADDR_WREG = 8'h05;
   localparam logic [7:0] ADDR_PCL = 8'h06;
   localparam logic [7:0] ADDR_TBLP = 8'h07;
   localparam logic [7:0] ADDR_TABLE_RESULT_HIGH = 8'h08;
   localparam logic [7:0] ADDR_TICK = 8'h09;
   localparam logic [7:0] ADDR_FLAG = 8'h0A;
   localparam logic [7:0] ADDR_IRQA = 8'h0B;
   localparam logic [7:0] ADDR_IRQB = 8'h1E;
   localparam logic [7:0] ADDR_TBHP = 8'h1F;
   localparam logic [7:0] GP_BASE = 8'h40;
   localparam int GP_WORDS = 768;

   // ----------------------------------------
   // field positions and masks
   // ----------------------------------------
   localparam logic [7:0] BANK_MASK = 8'h63;
   localparam int BANK_PROG_LSB = 5;
   localparam int BANK_DATA_LSB = 0;
   localparam int FLAG_C = 0;
   localparam int FLAG_AC = 1;
   localparam int FLAG_Z = 2;
   localparam int FLAG_OV = 3;
   localparam int FLAG_PDF = 4;
   localparam int FLAG_TO = 5;
   localparam logic [7:0] TICK_MASK = 8'h17;
   localparam int TICK_SEL_LSB = 0;
   localparam int TICK_SLOW_OSC_FAST_START_BIT = 4;
   localparam logic [15:0] TICK_BASE_PERIOD = 16'h0100;
   localparam int IRQ_EMI_BIT = 0;
   localparam logic [6:0] TBL_LAST_PAGE = 7'h7F;

   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic [7:0] BANK_RST = 8'h00;
   localparam logic [7:0] TICK_RST = 8'h00;
   localparam logic [7:0] REG_RST = 8'h00;

   // ----------------------------------------
   // alu operations and table read states
   // ----------------------------------------
   typedef enum logic [3:0] {
      ALU_NONE, ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC,
      ALU_AND, ALU_OR, ALU_XOR, ALU_RLC, ALU_RRC, ALU_LOAD
   } alu_op_t;

   typedef enum logic [1:0] {
      TB_IDLE, TB_FETCH, TB_WRITE
   } tbl_state_t;

endpackage : core_sfr_pkg

// ### verilog/core_special_registers.sv
// core special-function registers, general data memory and flag logic
`timescale 1ns/100ps
// ----------------------------------------
// ----------------------------------------
module core_special_registers
   import core_sfr_pkg::*;
(
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic [7:0] mem_addr_i,
   input wire logic mem_rd_i,
   input wire logic mem_wr_i,
   input wire logic [7:0] mem_wdata_i,
   output logic [7:0] mem_rdata_o,
   input alu_op_t alu_op_i,
   input wire logic [7:0] alu_operand_i,
   input wire logic [14:0] pc_i,
   output logic jump_o,
   output logic [14:0] jump_addr_o,
   output logic dummy_cycle_o,
   output logic [1:0] prog_bank_o,
   input wire logic tbl_rd_i,
   input wire logic tbl_last_i,
   input wire logic [7:0] tbl_dest_i,
   output logic tbl_req_o,
   output logic [14:0] tbl_addr_o,
   input wire logic tbl_ack_i,
   input wire logic [15:0] tbl_word_i,
   input wire logic halt_i,
   input wire logic kick_i,
   input wire logic wdt_expired_i,
   input wire logic irq_entry_i,
   input wire logic irq_return_i,
   input wire logic [6:0] irq_req_i,
   output logic irq_pending_o,
   input wire logic fs_tick_i,
   output logic tick_irq_o,
   output logic slow_osc_fast_start_o
);

   // ----------------------------------------
   // storage
   // ----------------------------------------
   logic [7:0] ptr0_q;
   logic [7:0] ptr1_q;
   logic [7:0] bank_q;
   logic [7:0] wreg_q;
   logic [7:0] tblp_q;
   logic [7:0] tbhp_q;
   logic [7:0] table_result_high_q;
   logic [7:0] tick_q;
   logic [3:0] arith_q;
   logic halt_flag_q;
   logic wdt_flag_q;
   logic [7:0] irqa_q;
   logic [7:0] irqb_q;
   logic [14:0] tick_cnt_q;
   logic [7:0] ram_q [0:GP_WORDS-1];
   tbl_state_t tbl_state_q;
   logic [7:0] tbl_dest_q;
   logic [7:0] tbl_low_q;

   // ----------------------------------------
   // address resolution
   // ----------------------------------------
   function automatic logic [9:0] resolve(input logic [7:0] a, input logic [7:0] p0,
                                          input logic [7:0] p1, input logic [1:0] db);
      if (a == ADDR_WIN0) begin
         resolve = {2'b00, p0};
      end else if (a == ADDR_WIN1) begin
         resolve = {db, p1};
      end else begin
         resolve = {db, a};
      end
   endfunction : resolve

   function automatic logic hollow(input logic [7:0] a, input logic [9:0] e);
      // a window reached through a window is not a real location
      hollow = (a == ADDR_WIN0 || a == ADDR_WIN1) &&
               (e[7:0] == ADDR_WIN0 || e[7:0] == ADDR_WIN1);
   endfunction : hollow

   function automatic logic [9:0] ram_index(input logic [9:0] e);
      ram_index = 10'({e[9:8], 7'h00}) + 10'({e[9:8], 6'h00}) + 10'(e[7:0] - GP_BASE);
   endfunction : ram_index

   logic [1:0] data_bank;
   assign data_bank = bank_q[BANK_DATA_LSB +: 2];

   // ----------------------------------------
   // write port: cpu write or table read completion
   // ----------------------------------------
   logic [7:0] wr_raw;
   logic [9:0] wr_eff;
   logic wr_go;
   logic [7:0] wr_data;
   logic wr_sfr;
   logic wr_ram;

   always_comb begin
      if (tbl_state_q == TB_WRITE) begin
         wr_raw = tbl_dest_q;
         wr_data = tbl_low_q;
         wr_go = 1'b1;
      end else begin
         wr_raw = mem_addr_i;
         wr_data = mem_wdata_i;
         wr_go = mem_wr_i;
      end
      wr_eff = resolve(wr_raw, ptr0_q, ptr1_q, data_bank);
      // special area ignores the bank bits entirely
      wr_sfr = wr_go && !hollow(wr_raw, wr_eff) && wr_eff[7:0] < GP_BASE;
      wr_ram = wr_go && wr_eff[7:0] >= GP_BASE;
   end

   // ----------------------------------------
   // read port
   // ----------------------------------------
   logic [9:0] rd_eff;
   logic [7:0] rd_val;

   always_comb begin
      rd_eff = resolve(mem_addr_i, ptr0_q, ptr1_q, data_bank);
      rd_val = 8'h00;
      if (hollow(mem_addr_i, rd_eff)) begin
         rd_val = 8'h00;
      end else if (rd_eff[7:0] >= GP_BASE) begin
         rd_val = ram_q[ram_index(rd_eff)];
      end else begin
         case (rd_eff[7:0])
            ADDR_PTR0: rd_val = ptr0_q;
            ADDR_PTR1: rd_val = ptr1_q;
            ADDR_BANK: rd_val = bank_q;
            ADDR_WREG: rd_val = wreg_q;
            ADDR_PCL: rd_val = pc_i[7:0];
            ADDR_TBLP: rd_val = tblp_q;
            ADDR_TBHP: rd_val = tbhp_q;
            ADDR_TABLE_RESULT_HIGH: rd_val = table_result_high_q;
            ADDR_TICK: rd_val = tick_q;
            ADDR_FLAG: rd_val = {2'b00, wdt_flag_q, halt_flag_q, arith_q};
            ADDR_IRQA: rd_val = irqa_q;
            ADDR_IRQB: rd_val = irqb_q;
            default: rd_val = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         mem_rdata_o <= REG_RST;
      end else if (mem_rd_i) begin
         mem_rdata_o <= rd_val;
      end
   end

   // general memory has no reset: its content is undefined at power-up
   always_ff @(posedge clk_i) begin
      if (wr_ram) begin
         ram_q[ram_index(wr_eff)] <= wr_data;
      end
   end

   // ----------------------------------------
   // pointers, bank and table pointers
   // ----------------------------------------
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ptr0_q <= REG_RST;
         ptr1_q <= REG_RST;
         tblp_q <= REG_RST;
         tbhp_q <= REG_RST;
      end else if (wr_sfr) begin
         if (wr_eff[7:0] == ADDR_PTR0) ptr0_q <= wr_data;
         if (wr_eff[7:0] == ADDR_PTR1) ptr1_q <= wr_data;
         if (wr_eff[7:0] == ADDR_TBLP) tblp_q <= wr_data;
         if (wr_eff[7:0] == ADDR_TBHP) tbhp_q <= wr_data;
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         bank_q <= BANK_RST;
      end else if (wdt_expired_i && !halt_flag_q) begin
         bank_q <= BANK_RST;
      end else if (wr_sfr && wr_eff[7:0] == ADDR_BANK) begin
         bank_q <= wr_data & BANK_MASK;
      end
   end

   assign prog_bank_o = bank_q[BANK_PROG_LSB +: 2];

   // ----------------------------------------
   // alu and working register
   // ----------------------------------------
   logic [7:0] b_op;
   logic cin;
   logic [8:0] sum;
   logic [4:0] nib;
   logic [7:0] low7;
   logic [7:0] res;
   logic new_c;
   logic do_arith;
   logic do_z;
   logic do_c;

   always_comb begin
      b_op = alu_operand_i;
      cin = 1'b0;
      case (alu_op_i)
         ALU_ADC: cin = arith_q[FLAG_C];
         ALU_SUB: begin
            b_op = ~alu_operand_i;
            cin = 1'b1;
         end
         ALU_SBC: begin
            b_op = ~alu_operand_i;
            cin = arith_q[FLAG_C];
         end
         default: cin = 1'b0;
      endcase
      // subtract is add of complement: carry out means no borrow
      sum = {1'b0, wreg_q} + {1'b0, b_op} + 9'(cin);
      nib = {1'b0, wreg_q[3:0]} + {1'b0, b_op[3:0]} + 5'(cin);
      low7 = {1'b0, wreg_q[6:0]} + {1'b0, b_op[6:0]} + 8'(cin);
      res = wreg_q;
      new_c = sum[8];
      do_arith = 1'b0;
      do_z = 1'b0;
      do_c = 1'b0;
      case (alu_op_i)
         ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC: begin
            res = sum[7:0];
            do_arith = 1'b1;
            do_z = 1'b1;
            do_c = 1'b1;
         end
         ALU_AND: begin
            res = wreg_q & alu_operand_i;
            do_z = 1'b1;
         end
         ALU_OR: begin
            res = wreg_q | alu_operand_i;
            do_z = 1'b1;
         end
         ALU_XOR: begin
            res = wreg_q ^ alu_operand_i;
            do_z = 1'b1;
         end
         ALU_RLC: begin
            res = {wreg_q[6:0], arith_q[FLAG_C]};
            new_c = wreg_q[7];
            do_c = 1'b1;
         end
         ALU_RRC: begin
            res = {arith_q[FLAG_C], wreg_q[7:1]};
            new_c = wreg_q[0];
            do_c = 1'b1;
         end
         ALU_LOAD: res = alu_operand_i;
         default: res = wreg_q;
      endcase
   end

   // the only alu destination is the working register
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         wreg_q <= REG_RST;
      end else if (alu_op_i != ALU_NONE) begin
         wreg_q <= res;
      end else if (wr_sfr && wr_eff[7:0] == ADDR_WREG) begin
         wreg_q <= wr_data;
      end
   end

   // ----------------------------------------
   // flag register
   // ----------------------------------------
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         arith_q <= 4'h0;
      end else begin
         if (wr_sfr && wr_eff[7:0] == ADDR_FLAG) begin
            arith_q <= wr_data[3:0];
         end
         if (do_c) arith_q[FLAG_C] <= new_c;
         if (do_arith) arith_q[FLAG_AC] <= nib[4];
         if (do_z) arith_q[FLAG_Z] <= (res == 8'h00);
         if (do_arith) arith_q[FLAG_OV] <= low7[7] ^ sum[8];
      end
   end

   // set wins over clear when both land together
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         halt_flag_q <= 1'b0;
      end else if (halt_i) begin
         halt_flag_q <= 1'b1;
      end else if (kick_i) begin
         halt_flag_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         wdt_flag_q <= 1'b0;
      end else if (wdt_expired_i) begin
         wdt_flag_q <= 1'b1;
      end else if (kick_i || halt_i) begin
         wdt_flag_q <= 1'b0;
      end
   end

   // ----------------------------------------
   // program counter low byte jump
   // ----------------------------------------
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         jump_o <= 1'b0;
         dummy_cycle_o <= 1'b0;
         jump_addr_o <= 15'h0000;
      end else begin
         jump_o <= wr_sfr && wr_eff[7:0] == ADDR_PCL;
         dummy_cycle_o <= wr_sfr && wr_eff[7:0] == ADDR_PCL;
         if (wr_sfr && wr_eff[7:0] == ADDR_PCL) begin
            jump_addr_o <= {pc_i[14:8], wr_data};
         end
      end
   end

   // ----------------------------------------
   // table read sequence
   // ----------------------------------------
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         tbl_state_q <= TB_IDLE;
         tbl_req_o <= 1'b0;
         tbl_addr_o <= 15'h0000;
         tbl_dest_q <= REG_RST;
         tbl_low_q <= REG_RST;
         table_result_high_q <= REG_RST;
      end else begin
         tbl_req_o <= 1'b0;
         case (tbl_state_q)
            TB_IDLE: begin
               if (tbl_rd_i) begin
                  tbl_addr_o <= {tbl_last_i ? TBL_LAST_PAGE : tbhp_q[6:0], tblp_q};
                  tbl_req_o <= 1'b1;
                  tbl_dest_q <= tbl_dest_i;
                  tbl_state_q <= TB_FETCH;
               end
            end
            TB_FETCH: begin
               if (tbl_ack_i) begin
                  table_result_high_q <= tbl_word_i[15:8];
                  tbl_low_q <= tbl_word_i[7:0];
                  tbl_state_q <= TB_WRITE;
               end
            end
            TB_WRITE: tbl_state_q <= TB_IDLE;
            default: tbl_state_q <= TB_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // tick divider and oscillator start
   // ----------------------------------------
   logic [14:0] tick_mask;
   assign tick_mask = 15'((TICK_BASE_PERIOD << tick_q[TICK_SEL_LSB +: 3]) - 16'h0001);

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         tick_q <= TICK_RST;
      end else if (wr_sfr && wr_eff[7:0] == ADDR_TICK) begin
         tick_q <= wr_data & TICK_MASK;
      end
   end

   // free-running count: the first period after a select change can be short, later ones are exact
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         tick_cnt_q <= 15'h0000;
         tick_irq_o <= 1'b0;
      end else begin
         tick_irq_o <= fs_tick_i && (tick_cnt_q & tick_mask) == tick_mask;
         if (fs_tick_i) tick_cnt_q <= tick_cnt_q + 15'h0001;
      end
   end

   assign slow_osc_fast_start_o = tick_q[TICK_SLOW_OSC_FAST_START_BIT];

   // ----------------------------------------
   // interrupt control
   // ----------------------------------------
   // only the global enable changes on entry; flags are never stacked
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         irqa_q <= REG_RST;
         irqb_q <= REG_RST;
      end else begin
         if (wr_sfr && wr_eff[7:0] == ADDR_IRQA) irqa_q <= wr_data;
         if (wr_sfr && wr_eff[7:0] == ADDR_IRQB) irqb_q <= wr_data;
         if (irq_entry_i) irqa_q[IRQ_EMI_BIT] <= 1'b0;
         if (irq_return_i) irqa_q[IRQ_EMI_BIT] <= 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         irq_pending_o <= 1'b0;
      end else begin
         irq_pending_o <= irqa_q[IRQ_EMI_BIT] &&
                          |(irq_req_i & {irqb_q[3:0], irqa_q[3:1]});
      end
   end

endmodule : core_special_registers
